// File: hw/stopwatch_pkg.sv
// Purpose: shared constants and types of the latency stopwatch
// Assumes: 16-bit management words, one core clock
// Notes: offsets are management register addresses
package stopwatch_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_CONTROL = 16'h8040;  // control word
   localparam logic [15:0] ADDR_TALLY_HI = 16'h8041; // flags, tally high
   localparam logic [15:0] ADDR_TALLY_LO = 16'h8042; // tally low
   localparam logic [15:0] ADDR_CLEAR = 16'h0018;    // read clears result
   localparam logic [15:0] ADDR_IRQ_STAT = 16'h8043; // sticky events
   localparam logic [15:0] ADDR_IRQ_MASK = 16'h8044; // event mask
   localparam logic [4:0] MGMT_DEVICE = 5'h1E;       // management device

   // ----------------------------------------------------------------
   // control word fields
   // ----------------------------------------------------------------
   localparam int START_LSB = 6;  // start choice [7:6]
   localparam int DIV_LSB = 4;    // clock divider [5:4]
   localparam int STOP_LSB = 2;   // stop choice [3:2]
   localparam int ON_BIT = 1;     // measurement enable
   localparam int CLKSEL_BIT = 0; // measurement clock source
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_MASK = 16'h00FF; // writable bits

   // ----------------------------------------------------------------
   // result word fields
   // ----------------------------------------------------------------
   localparam int START_FOUND_LSB = 12; // start comma flags [15:12]
   localparam int STOP_FOUND_LSB = 8;   // stop comma flags [11:8]
   localparam int READY_BIT = 4;        // result valid
   localparam int TALLY_W = 20;
   localparam logic [19:0] TALLY_MAX = 20'hFFFFF;
   localparam logic [19:0] TALLY_RESET = 20'h00000;

   // ----------------------------------------------------------------
   // interrupt bits
   // ----------------------------------------------------------------
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE_BIT = 0; // measurement finished
   localparam int IRQ_SAT_BIT = 1;  // tally saturated
   localparam logic [1:0] IRQ_RESET = 2'h0;

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   localparam int DIV_CNT_W = 3; // counts up to divide by 8

   // measurement sequence, gray along idle-run-done
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_RUN = 2'h1,
      ST_DONE = 2'h3
   } meas_state_t;

endpackage

// File: hw/pin_edge_sync.sv
// Purpose: bring an outside level into the core clock and find edges
// Assumes: level changes slower than the core clock
// Notes: first flop feeds only the second flop
`timescale 1ns/1ps
module pin_edge_sync
   import stopwatch_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // outside level
   input wire logic pin_in,
   // edge pulses
   output logic rise,
   output logic fall
);

   logic meta_r;  // first synchroniser stage
   logic sync_r;  // second synchroniser stage
   logic prev_r;  // delayed copy for edge detection

   // ----------------------------------------------------------------
   // two-flop synchroniser plus history
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // one-cycle edge pulses from the synchronised level
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;

endmodule

// File: hw/meas_divider.sv
// Purpose: power-of-two tick generator for the measurement clock
// Assumes: code 0..3 selects divide by 1, 2, 4, 8
// Notes: tick is a one-cycle enable, never a clock
`timescale 1ns/1ps
module meas_divider
   import stopwatch_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // control
   input wire logic run,
   input wire logic [1:0] div_code,
   // enable pulse
   output logic tick
);

   logic [DIV_CNT_W-1:0] cnt_r;  // cycles since last tick
   logic [DIV_CNT_W-1:0] last;   // terminal count for the code

   // terminal count is divide ratio minus one
   always_comb
   begin
      case (div_code)
         2'h0: last = 3'h0;
         2'h1: last = 3'h1;
         2'h2: last = 3'h3;
         2'h3: last = 3'h7;
         default: last = 3'h0;
      endcase
   end

   assign tick = run & (cnt_r >= last);

   // ----------------------------------------------------------------
   // divide counter, parked at zero while not running
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         cnt_r <= 3'h0;
      else if (!run || tick)
         cnt_r <= 3'h0;
      else
         cnt_r <= cnt_r + 3'h1;
   end

endmodule

// File: hw/latency_stopwatch_control.sv
// Purpose: per-channel latency stopwatch with its register file
// Assumes: path events are core-clock pulses; pin and byte clock async
// Notes: tally unit is half a measurement clock period
//
// Behaviour
// - start choice picks low rx, high tx, pin rise
// - stop choice picks low tx, high rx, pin fall
// - divider code divides by 1, 2, 4, 8
// - divider used only when clock source zero
// - enable bit gates measurement, off after reset
// - control word reads zero after reset
// - control word at 0x8040, low eight bits read/write, upper bits read zero
// - bit zero picks divided or recovered clock
// - 20-bit saturating tally with ready flag
// - reading 0x0018 clears tally and flags
`timescale 1ns/1ps
module latency_stopwatch_control
   import stopwatch_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // datapath comma events, core clock pulses
   input wire logic [3:0] ls_rx_comma,
   input wire logic [1:0] hs_tx_comma,
   input wire logic [3:0] ls_tx_comma,
   input wire logic [1:0] hs_rx_comma,
   // asynchronous inputs
   input wire logic external_marker_pin,
   input wire logic recovered_byte_clk,
   // results
   output logic [19:0] stopwatch_tally,
   output logic stopwatch_result_valid,
   output logic irq
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // event for a two-bit choice: 00 low path, 01 high path, 1x pin
   function automatic logic pick_event(input logic [1:0] sel,
      input logic ls_ev, input logic hs_ev, input logic pin_ev);
      if (sel[1])
         pick_event = pin_ev;
      else if (sel[0])
         pick_event = hs_ev;
      else
         pick_event = ls_ev;
   endfunction

   // comma location flags for a two-bit choice
   function automatic logic [3:0] pick_lanes(input logic [1:0] sel,
      input logic [3:0] ls_lanes, input logic [1:0] hs_lanes);
      if (sel[1])
         pick_lanes = 4'h0;
      else if (sel[0])
         pick_lanes = {2'h0, hs_lanes};
      else
         pick_lanes = ls_lanes;
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [15:0] control_r;      // control word
   logic [1:0] start_choice;    // start event selection
   logic [1:0] stop_choice;     // stop event selection
   logic [1:0] clock_divider;   // divider code
   logic stopwatch_on;          // measurement enable
   logic clock_source;          // 0 divided, 1 recovered byte clock
   meas_state_t state_r;        // measurement sequence
   logic [3:0] start_found_r;   // start comma flags
   logic [3:0] stop_found_r;    // stop comma flags
   logic [IRQ_W-1:0] irq_stat_r; // sticky events
   logic [IRQ_W-1:0] irq_mask_r; // event enables
   logic [15:0] rdata_nxt;      // read data next cycle
   logic pin_rise, pin_fall;    // marker pin edges
   logic bclk_rise, bclk_fall;  // byte clock edges
   logic div_tick;              // divided clock period
   logic meas_tick;             // one tally step due
   logic [19:0] step;           // half periods per step
   logic [20:0] sum;            // tally plus step, with carry
   logic start_ev, stop_ev;     // selected events
   logic clr_read;              // read of the clear address
   logic hold_done;             // stop beats a clearing read
   logic done_ev, sat_ev;       // interrupt sources

   assign start_choice = control_r[START_LSB +: 2];
   assign clock_divider = control_r[DIV_LSB +: 2];
   assign stop_choice = control_r[STOP_LSB +: 2];
   assign stopwatch_on = control_r[ON_BIT];
   assign clock_source = control_r[CLKSEL_BIT];

   // ----------------------------------------------------------------
   // asynchronous inputs and measurement clock
   // ----------------------------------------------------------------
   pin_edge_sync u_marker_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .pin_in(external_marker_pin),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   pin_edge_sync u_byteclk_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .pin_in(recovered_byte_clk),
      .rise(bclk_rise),
      .fall(bclk_fall)
   );

   // divider runs only on the internal source
   meas_divider u_divider (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .run(stopwatch_on & ~clock_source),
      .div_code(clock_divider),
      .tick(div_tick)
   );

   // divided tick is a full period, each byte clock edge a half
   always_comb
   begin
      if (clock_source)
      begin
         meas_tick = bclk_rise | bclk_fall;
         step = 20'h00001;
      end
      else
      begin
         meas_tick = div_tick;
         step = 20'h00002;
      end
   end

   // ----------------------------------------------------------------
   // event selection
   // ----------------------------------------------------------------
   assign start_ev = pick_event(start_choice, |ls_rx_comma,
      |hs_tx_comma, pin_rise);
   assign stop_ev = pick_event(stop_choice, |ls_tx_comma,
      |hs_rx_comma, pin_fall);
   assign clr_read = reg_rd & (reg_addr == ADDR_CLEAR);
   // a stop in the same cycle as a clear keeps its result
   assign hold_done = (state_r == ST_RUN) & stopwatch_on & stop_ev;
   assign sum = {1'b0, stopwatch_tally} + {1'b0, step};
   assign done_ev = hold_done;
   // saturation event on the step that first reaches the top value
   assign sat_ev = (state_r == ST_RUN) & stopwatch_on & meas_tick
      & (stopwatch_tally != TALLY_MAX)
      & (sum[20] | (sum[19:0] == TALLY_MAX));

   // ----------------------------------------------------------------
   // control word
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         control_r <= CONTROL_RESET;
      else if (reg_wr && reg_addr == ADDR_CONTROL)
         control_r <= reg_wdata & CONTROL_MASK;
   end

   // ----------------------------------------------------------------
   // measurement sequence
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         state_r <= ST_IDLE;
      else if (clr_read && !hold_done)
         state_r <= ST_IDLE;
      else
      begin
         case (state_r)
            // wait for the start event while enabled
            ST_IDLE:
               if (stopwatch_on && start_ev)
                  state_r <= ST_RUN;
            // count until stop, abort when disabled
            ST_RUN:
               if (!stopwatch_on)
                  state_r <= ST_IDLE;
               else if (stop_ev)
                  state_r <= ST_DONE;
            // hold the result until cleared
            ST_DONE:
               state_r <= ST_DONE;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // tally, saturating
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         stopwatch_tally <= TALLY_RESET;
      else if (clr_read && !hold_done)
         stopwatch_tally <= TALLY_RESET;
      else if (state_r == ST_RUN && stopwatch_on && meas_tick)
      begin
         if (sum[20])
            stopwatch_tally <= TALLY_MAX;
         else
            stopwatch_tally <= sum[19:0];
      end
   end

   // ----------------------------------------------------------------
   // ready and comma flags
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stopwatch_result_valid <= 1'b0;
         start_found_r <= 4'h0;
         stop_found_r <= 4'h0;
      end
      else if (hold_done)
      begin
         stopwatch_result_valid <= 1'b1;
         stop_found_r <= pick_lanes(stop_choice, ls_tx_comma,
            hs_rx_comma);
      end
      else if (clr_read)
      begin
         stopwatch_result_valid <= 1'b0;
         start_found_r <= 4'h0;
         stop_found_r <= 4'h0;
      end
      else if (state_r == ST_IDLE && stopwatch_on && start_ev)
         start_found_r <= pick_lanes(start_choice, ls_rx_comma,
            hs_tx_comma);
   end

   // ----------------------------------------------------------------
   // interrupt status and mask, a new event beats the clear
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         irq_stat_r <= IRQ_RESET;
      else
      begin
         for (int i = 0; i < IRQ_W; i++)
         begin
            if ((i == IRQ_DONE_BIT && done_ev) ||
                (i == IRQ_SAT_BIT && sat_ev))
               irq_stat_r[i] <= 1'b1;
            else if (reg_wr && reg_addr == ADDR_IRQ_STAT && reg_wdata[i])
               irq_stat_r[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         irq_mask_r <= IRQ_RESET;
      else if (reg_wr && reg_addr == ADDR_IRQ_MASK)
         irq_mask_r <= reg_wdata[IRQ_W-1:0];
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   // ----------------------------------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------------------------------
   always_comb
   begin
      rdata_nxt = 16'h0000;
      case (reg_addr)
         ADDR_CONTROL: rdata_nxt = control_r;
         ADDR_TALLY_HI: rdata_nxt = {start_found_r, stop_found_r,
            3'h0, stopwatch_result_valid, stopwatch_tally[19:16]};
         ADDR_TALLY_LO: rdata_nxt = stopwatch_tally[15:0];
         ADDR_IRQ_STAT: rdata_nxt = {14'h0000, irq_stat_r};
         ADDR_IRQ_MASK: rdata_nxt = {14'h0000, irq_mask_r};
         default: rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
      else
         reg_rdata <= 16'h0000;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_start_taken: assert property (
      state_r == ST_IDLE && stopwatch_on && start_choice[1] && pin_rise
      && !clr_read |=> state_r == ST_RUN)
      else $error("pin rise did not start the stopwatch");
   a_stop_taken: assert property (
      state_r == ST_RUN && stopwatch_on && stop_choice == 2'h0
      && |ls_tx_comma |=> state_r == ST_DONE && stopwatch_result_valid)
      else $error("low tx comma did not stop the stopwatch");
   a_div_two: assert property (
      div_tick && clock_divider == 2'h1 && !reg_wr |=> !div_tick)
      else $error("divide by two ticked twice in a row");
   a_div_ignored: assert property (
      clock_source |-> !div_tick)
      else $error("divider ticked on the recovered clock source");
   a_off_aborts: assert property (
      state_r == ST_RUN && !stopwatch_on && !clr_read
      |=> state_r == ST_IDLE && $stable(stopwatch_tally))
      else $error("disabled measurement kept running");
   a_ctrl_write: assert property (
      reg_wr && reg_addr == ADDR_CONTROL
      |=> control_r == ($past(reg_wdata) & CONTROL_MASK))
      else $error("control word write lost");
   a_tally_step: assert property (
      state_r == ST_RUN && stopwatch_on && div_tick && !clock_source
      && stopwatch_tally < 20'hFFFF0 && !clr_read
      |=> stopwatch_tally == $past(stopwatch_tally) + 20'h00002)
      else $error("tally did not step by two half periods");
   a_tally_sat: assert property (
      stopwatch_tally == TALLY_MAX && !clr_read |=> stopwatch_tally == TALLY_MAX)
      else $error("saturated tally wrapped");
   a_clear_read: assert property (
      clr_read && !hold_done |=> stopwatch_tally == TALLY_RESET
      && !stopwatch_result_valid && start_found_r == 4'h0)
      else $error("read of clear address left a result");
   a_done_hold: assert property (
      state_r == ST_DONE && !clr_read |=> $stable(stopwatch_tally)
      && state_r == ST_DONE)
      else $error("finished result changed before clear");

   c_done: cover property (state_r == ST_RUN ##1 state_r == ST_DONE);
   c_saturate: cover property (sat_ev);
   c_pin_start: cover property (state_r == ST_IDLE && stopwatch_on
      && start_choice[1] && pin_rise);
   c_clear: cover property (clr_read && stopwatch_result_valid);

endmodule

// File: bench/tb_top.sv
// Purpose: self-checking bench for the latency stopwatch
// Assumes: read data stand the cycle after the read strobe
// Notes: saturation needs too many cycles; design assertions cover it
`timescale 1ns/1ps
module tb_top import stopwatch_pkg::*; ;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic core_clk;
   logic arst_n;
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic [3:0] ls_rx; // start lanes
   logic [1:0] hs_tx; // start halves
   logic [3:0] ls_tx; // stop lanes
   logic [1:0] hs_rx; // stop halves
   logic pin; // external marker level
   logic bclk; // recovered byte clock
   logic [19:0] tally;
   logic valid;
   logic irq;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0; // timeout counter

   latency_stopwatch_control DUT (
      .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ls_rx_comma(ls_rx), .hs_tx_comma(hs_tx),
      .ls_tx_comma(ls_tx), .hs_rx_comma(hs_rx),
      .external_marker_pin(pin), .recovered_byte_clk(bclk),
      .stopwatch_tally(tally), .stopwatch_result_valid(valid),
      .irq(irq));

   // ---------------------------------------------------------------
   // clock and hang guard
   // ---------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // a hang counts as a mismatch and closes the run
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // compare and access tasks
   // ---------------------------------------------------------------
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_tally(input logic [19:0] exp);
      check_count++;
      if (tally !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, tally, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [15:0] a, input logic [15:0] w);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // one-cycle read strobe, data taken the cycle after
   task automatic rc(input logic [15:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk_reg(reg_rdata, exp);
   endtask

   // control word from its fields
   function automatic logic [15:0] ctl(input logic [1:0] st, dv, sp,
                                       input logic on, src);
      return {8'h00, st, dv, sp, on, src};
   endfunction

   // start (s=1) or stop (s=0) event of choice c, two edges long
   task automatic go(input logic [1:0] c, input logic s);
      @(posedge core_clk);
      if (c[1])
         pin <= s;
      else if (s)
         if (c[0]) hs_tx <= 2'h2; else ls_rx <= 4'hA;
      else
         if (c[0]) hs_rx <= 2'h1; else ls_tx <= 4'h5;
      @(posedge core_clk);
      ls_rx <= 4'h0;
      hs_tx <= 2'h0;
      ls_tx <= 4'h0;
      hs_rx <= 2'h0;
   endtask

   // start, wait, decoy stop of another path, real stop, settle
   task automatic meas(input logic [1:0] st, sp, dv, input logic src,
                       input int g);
      // pin parked opposite to the edge that the run will need
      @(posedge core_clk);
      pin <= st[1] ? 1'b0 : sp[1];
      wr(ADDR_CONTROL, ctl(st, dv, sp, 1'b1, src));
      go(st, 1'b1);
      for (int i = 0; i < g - 2; i++)
      begin
         @(posedge core_clk);
         if (src && i % 4 == 0 && i < 24)
            bclk <= ~bclk;
      end
      go(sp[1] ? 2'b00 : {1'b0, ~sp[0]}, 1'b0);
      go(sp, 1'b0);
      repeat (6) @(posedge core_clk);
      #1;
   endtask

   // clearing read, then sticky done bit cleared by writing one
   task automatic clr();
      rc(ADDR_CLEAR, 16'h0000);
      chk_tally(20'h00000);
      chk_bit(valid, 1'b0);
      wr(ADDR_IRQ_STAT, 16'h0003);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin : main
      logic [1:0] st;
      logic [1:0] sp;
      logic [3:0] sf;
      logic [3:0] pf;
      logic [19:0] tv; // expected tally of one run
      int e;
      arst_n = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ls_rx = 4'h0;
      hs_tx = 2'h0;
      ls_tx = 4'h0;
      hs_rx = 2'h0;
      pin = 1'b0;
      bclk = 1'b0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      // reset values and access kinds
      rc(ADDR_CONTROL, 16'h0000);
      rc(ADDR_TALLY_HI, 16'h0000);
      rc(ADDR_IRQ_MASK, 16'h0000);
      chk_bit(irq, 1'b0);
      wr(ADDR_CONTROL, 16'hFFFF);
      rc(ADDR_CONTROL, 16'h00FF);
      wr(16'h8045, 16'hFFFF);
      rc(16'h8045, 16'h0000);
      // disabled: events leave no result
      wr(ADDR_CONTROL, 16'h0000);
      go(2'b00, 1'b1);
      go(2'b00, 1'b0);
      repeat (3) @(posedge core_clk);
      chk_bit(valid, 1'b0);
      // enabled, wrong start path only: nothing starts
      wr(ADDR_CONTROL, ctl(2'b00, 2'b00, 2'b00, 1'b1, 1'b0));
      go(2'b01, 1'b1);
      go(2'b00, 1'b0);
      repeat (3) @(posedge core_clk);
      chk_bit(valid, 1'b0);
      chk_tally(20'h00000);
      wr(ADDR_IRQ_MASK, 16'h0001);
      // every start and stop code, divide by one
      for (int m = 0; m < 4; m++)
      begin
         st = m[1:0];
         sp = 2'(3 - m);
         sf = st[1] ? 4'h0 : (st[0] ? 4'h2 : 4'hA);
         pf = sp[1] ? 4'h0 : (sp[0] ? 4'h1 : 4'h5);
         // pin events pass the synchroniser, two edges later than commas
         tv = 20'h00018 + (sp[1] ? 20'h00004 : 20'h00000);
         tv = tv - (st[1] ? 20'h00004 : 20'h00000);
         meas(st, sp, 2'b00, 1'b0, 10);
         chk_tally(tv);
         chk_bit(valid, 1'b1);
         chk_bit(irq, 1'b1);
         rc(ADDR_TALLY_HI, {sf, pf, 8'h10});
         rc(ADDR_TALLY_LO, tv[15:0]);
         rc(ADDR_IRQ_STAT, 16'h0001);
         if (m == 0)
         begin
            wr(ADDR_IRQ_MASK, 16'h0000);
            chk_bit(irq, 1'b0);
            wr(ADDR_IRQ_MASK, 16'h0001);
         end
         clr();
         chk_bit(irq, 1'b0);
      end
      // stop while idle after clearing is ignored
      go(2'b00, 1'b0);
      repeat (3) @(posedge core_clk);
      chk_bit(valid, 1'b0);
      // divider codes: 64 core cycles, one phase of slack
      for (int d = 0; d < 4; d++)
      begin
         meas(2'b00, 2'b00, 2'(d), 1'b0, 62);
         e = 128 >> d;
         chk_bit(int'(tally) >= e - 2 && int'(tally) <= e + 2, 1'b1);
         clr();
      end
      // byte clock source ignores divide code: six edges counted
      meas(2'b00, 2'b00, 2'b11, 1'b1, 30);
      chk_tally(20'h00006);
      chk_bit(valid, 1'b1);
      clr();
      // enable cleared mid-run aborts without a result
      wr(ADDR_CONTROL, ctl(2'b00, 2'b00, 2'b00, 1'b1, 1'b0));
      go(2'b00, 1'b1);
      wr(ADDR_CONTROL, 16'h0000);
      go(2'b00, 1'b0);
      repeat (3) @(posedge core_clk);
      chk_bit(valid, 1'b0);
      rc(ADDR_IRQ_STAT, 16'h0000);
      clr();
      end_of_test();
   end

   // ---------------------------------------------------------------
   // verdict
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

endmodule
